// File: hw/fsc_target.sv
// Summary of operation
// - checksum spans byte two to page end
// - each byte enters msb first
// - poly 8005h, seed 4F4Eh, no tweaks
// - signature 45h 50h 50h 53h at 2-5
// - section zero at 32, type 16, length 17
// - section length counts sixteen byte units
// - absent sections carry zero type, length
// - sections packed back to back
// - identifier then its inverse, 32 bytes
// - sixteen copies back to back, 512 bytes
// - erase passes when fail bit clear
// - bad block erase skipped, fail set
// - plain status ORs plane fail bits
// - status byte repeated twice in ddr
// - status rereadable with strobe held
// - ddr2 status live, strobe on edges
// - enhanced status picks lun, plane from row
// - enhanced status keeps data source
// - status byte bit layout
// - unselected lun releases its drivers
// - enhanced status opcode 78h
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_target #(
  parameter int unsigned ERASE_US = `ERASE_US_DEF,
  parameter logic LUN_ID = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // flash bus pins
  input wire fsc_pkg::fsc_pins_t pins,
  output fsc_pkg::fsc_drv_t drv,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);
  import fsc_pkg::*;

  localparam int unsigned ERASE_CYC = ERASE_US * `CLK_MHZ;

  // checksum of one byte, msb first, no reflection
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int k = 7; k >= 0; k--) begin
      fb = r[15] ^ d[k];
      r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // extended page image, one byte per index
  function automatic logic [7:0] ext_byte(input logic [9:0] i, input logic [63:0] ecc,
                                          input logic [15:0] crc);
    logic [7:0] b;
    b = 8'h00;
    if (i == `EXT_CRC_LO) b = crc[7:0];
    else if (i == `EXT_CRC_HI) b = crc[15:8];
    else if (i == `EXT_SIG0_AT) b = `EXT_SIG0;
    else if (i == `EXT_SIG1_AT) b = `EXT_SIG1;
    else if (i == `EXT_SIG2_AT) b = `EXT_SIG2;
    else if (i == `EXT_SIG3_AT) b = `EXT_SIG3;
    else if (i == `SEC0_TYPE_AT) b = `SEC0_TYPE;
    else if (i == `SEC0_LEN_AT) b = `SEC0_LEN;
    // single section right at its base
    else if (i >= `SEC0_BASE && i < `ECC_END) b = ecc[{i[2:0], 3'b000} +: 8];
    // sections one to seven stay zero
    return b;
  endfunction

  // identifier copies, inverse in the upper half of each 32
  function automatic logic [7:0] uid_byte(input logic [9:0] i, input logic [127:0] u);
    logic [7:0] b;
    b = u[{i[3:0], 3'b000} +: 8];
    if (i >= `UID_SPAN) return 8'h00;
    return i[4] ? ~b : b;
  endfunction

  // status byte assembly, shared by both status commands
  function automatic logic [7:0] mk_status(input logic wp, input logic rdy,
                                           input fsc_plane_t p);
    logic [7:0] s;
    s = 8'h00;
    s[`SB_WP] = wp;
    s[`SB_RDY] = rdy;
    s[`SB_ARRAY_READY_FLAG] = rdy;
    s[`SB_CSP] = p.command_specific_flag;
    s[`SB_PRIOR_OP_FAILED_FLAG] = p.prior_op_failed_flag;
    s[`SB_FAIL] = p.fail;
    return s;
  endfunction

  fsc_pins_t pin_s1_r, pin_s2_r, pin_s3_r;
  fsc_state_t st_r, st_nxt;
  fsc_src_t src_r, src_nxt, dsrc_r, dsrc_nxt;
  logic [23:0] row_r, row_nxt;
  logic [1:0] acnt_r, acnt_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [9:0] idx_r, idx_nxt;
  logic lun_sel_r, lun_sel_nxt, plane_sel_r, plane_sel_nxt;
  logic started_r, div_r, busy_r, eplane_r;
  logic [31:0] erase_cnt_r;
  logic [15:0] crc_r, crc_fin_r;
  logic [9:0] crc_idx_r;
  logic crc_busy_r;
  fsc_plane_t pl_r [2];
  logic [31:0] rw_r [`NUM_REGS];
  fsc_drv_t drv_nxt;

  // two-stage pin synchroniser, third stage for edge detection
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_s1_r <= fsc_pins_t'(`PINS_IDLE);
      pin_s2_r <= fsc_pins_t'(`PINS_IDLE);
      pin_s3_r <= fsc_pins_t'(`PINS_IDLE);
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // register fields
  wire fsc_mode_t mode = fsc_mode_t'(rw_r[`REG_CTRL][`CTRL_MODE_HI:`CTRL_MODE_LO]);
  wire wp_off = rw_r[`REG_CTRL][`CTRL_WP];
  wire [127:0] unique_identifier = {rw_r[`REG_UID0 + 4'h3], rw_r[`REG_UID0 + 4'h2],
                      rw_r[`REG_UID0 + 4'h1], rw_r[`REG_UID0]};
  wire [63:0] ecc = {rw_r[`REG_ECC1], rw_r[`REG_ECC0]};

  // bus edges; commands latch on the rising write strobe
  wire live = !pin_s2_r.ce_n;
  wire we_rise = live && !pin_s3_r.we_n && pin_s2_r.we_n;
  wire re_fall = pin_s3_r.re_n && !pin_s2_r.re_n;
  wire re_rise = !pin_s3_r.re_n && pin_s2_r.re_n;
  wire cmd_lat = we_rise && pin_s2_r.cle && !pin_s2_r.ale;
  wire adr_lat = we_rise && pin_s2_r.ale && !pin_s2_r.cle;
  wire [7:0] bus_in = pin_s2_r.dq;
  wire ddr1_win = live && pin_s2_r.ale && pin_s2_r.cle;

  // output events per interface mode
  logic out_evt;
  // ddr1 reads while ale/cle stay 11b
  assign out_evt = (mode == FSC_DDR1) ? (ddr1_win && div_r) :
                   (mode == FSC_DDR2) ? (re_fall || re_rise) : re_fall;

  // status views: composite across planes, or one plane
  // fail bits ORed over planes
  wire fsc_plane_t pl_or = fsc_plane_t'(pl_r[0] | pl_r[1]);
  wire [7:0] sb_plain = mk_status(wp_off, !busy_r, pl_or);
  wire [7:0] sb_enh = mk_status(wp_off, !busy_r, pl_r[plane_sel_r]);

  // byte source for the current output
  logic [7:0] byte_now;
  always_comb begin
    unique case (src_r)
      FSC_STAT: byte_now = sb_plain;
      FSC_ENH: byte_now = sb_enh;
      FSC_UIDS: byte_now = uid_byte(idx_r, unique_identifier);
      FSC_EXTP: byte_now = ext_byte(idx_r, ecc, crc_fin_r);
      default: byte_now = 8'h00;
    endcase
  end

  wire status_src = (src_r == FSC_STAT) || (src_r == FSC_ENH);
  // deselected lun keeps its drivers off
  wire out_on = (st_r == FSC_OUT) && (src_r != FSC_NONE) && live && lun_sel_r;
  wire evt_on = out_evt && out_on;
  wire oe_now = (mode == FSC_DDR1) ? (out_on && ddr1_win) :
                (mode == FSC_DDR2) ? (out_on && (started_r || out_evt)) :
                (out_on && !pin_s2_r.re_n);

  // bad-block lookup against the block part of the row
  logic [`NUM_BAD-1:0] bad_hit;
  for (genvar g = 0; g < `NUM_BAD; g++) begin : g_bad
    assign bad_hit[g] = rw_r[`REG_BAD0 + g][`BAD_VALID] &&
      (rw_r[`REG_BAD0 + g][`BAD_BLK_HI:0] == row_r[`BLK_HI:`BLK_LO]);
  end
  wire erase_go = (st_r == FSC_CONF) && cmd_lat && (bus_in == `CMD_ERASE_GO) && !busy_r;
  wire erase_bad = |bad_hit;
  wire erase_done = busy_r && (erase_cnt_r == 32'h0000_0000);

  // command interpreter next state
  always_comb begin
    st_nxt = st_r;
    src_nxt = src_r;
    dsrc_nxt = dsrc_r;
    row_nxt = row_r;
    acnt_nxt = acnt_r;
    pend_nxt = pend_r;
    idx_nxt = idx_r;
    lun_sel_nxt = lun_sel_r;
    plane_sel_nxt = plane_sel_r;
    if (cmd_lat) begin
      st_nxt = FSC_IDLE;
      src_nxt = FSC_NONE;
      acnt_nxt = 2'd0;
      pend_nxt = bus_in;
      if (bus_in == `CMD_STATUS) begin
        st_nxt = FSC_OUT;
        src_nxt = FSC_STAT;
      end else if (bus_in == `CMD_STATUS_ENH || bus_in == `CMD_ERASE ||
                   bus_in == `CMD_UID || bus_in == `CMD_PARAM) begin
        st_nxt = FSC_ADDR;
      // resume the stream the last read chose
      end else if (bus_in == `CMD_DATA) begin
        st_nxt = FSC_OUT;
        src_nxt = dsrc_r;
      end
      if (st_r == FSC_CONF && bus_in == `CMD_ERASE_GO) st_nxt = FSC_IDLE;
    end else if (adr_lat && st_r == FSC_ADDR) begin
      // row bytes arrive least significant first
      row_nxt = {bus_in, row_r[23:8]};
      acnt_nxt = acnt_r + 2'd1;
      if (pend_r == `CMD_UID || pend_r == `CMD_PARAM) begin
        st_nxt = FSC_OUT;
        idx_nxt = 10'd0;
        src_nxt = (pend_r == `CMD_UID) ? FSC_UIDS :
                  (bus_in == `ADDR_EXTP) ? FSC_EXTP : FSC_NONE;
        dsrc_nxt = src_nxt;
      end else if (acnt_r + 2'd1 == `ROW_CYCLES) begin
        if (pend_r == `CMD_ERASE) begin
          st_nxt = FSC_CONF;
        end else begin
          // lun and plane from the three row bytes
          st_nxt = FSC_OUT;
          src_nxt = FSC_ENH;
          lun_sel_nxt = (row_nxt[`LUN_BIT] == LUN_ID);
          plane_sel_nxt = row_nxt[`PLANE_BIT];
        end
      end
    end else if (evt_on && !status_src) begin
      idx_nxt = idx_r + 10'd1;
    end
  end

  // command state registers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= FSC_IDLE;
      src_r <= FSC_NONE;
      dsrc_r <= FSC_NONE;
      row_r <= 24'h000000;
      acnt_r <= 2'd0;
      pend_r <= 8'h00;
      idx_r <= 10'd0;
      lun_sel_r <= 1'b1;
      plane_sel_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      dsrc_r <= dsrc_nxt;
      row_r <= row_nxt;
      acnt_r <= acnt_nxt;
      pend_r <= pend_nxt;
      idx_r <= idx_nxt;
      lun_sel_r <= lun_sel_nxt;
      plane_sel_r <= plane_sel_nxt;
    end
  end

  // erase timer; busy drops the ready bit until done
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_r <= 1'b0;
      erase_cnt_r <= 32'h0000_0000;
      eplane_r <= 1'b0;
    end else if (erase_go && !erase_bad) begin
      busy_r <= 1'b1;
      erase_cnt_r <= ERASE_CYC - 32'd1;
      eplane_r <= row_r[`PLANE_BIT];
    end else if (erase_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      erase_cnt_r <= erase_cnt_r - 32'd1;
    end
  end

  // per-plane result bits; prior result slides into prior_op_failed_flag
  for (genvar p = 0; p < 2; p++) begin : g_plane
    always_ff @(posedge clock) begin
      if (srst) begin
        pl_r[p] <= '0;
      end else if (erase_go && row_r[`PLANE_BIT] == p) begin
        // fail clear means the erase passed
        pl_r[p].prior_op_failed_flag <= pl_r[p].fail;
        pl_r[p].fail <= erase_bad;
      end
    end
  end

  // checksum engine reruns whenever the section data changes
  wire ecc_wr;
  always_ff @(posedge clock) begin
    if (srst || ecc_wr) begin
      crc_r <= `CRC_INIT;
      crc_fin_r <= `CRC_INIT;
      crc_idx_r <= `EXT_FIRST;
      crc_busy_r <= 1'b1;
    end else if (crc_busy_r) begin
      crc_r <= crc_step(crc_r, ext_byte(crc_idx_r, ecc, 16'h0000));
      crc_idx_r <= crc_idx_r + 10'd1;
      if (crc_idx_r == `EXT_LAST) begin
        crc_busy_r <= 1'b0;
        crc_fin_r <= crc_step(crc_r, ext_byte(crc_idx_r, ecc, 16'h0000));
      end
    end
  end

  // output drive; status stays live, data moves only on events
  always_comb begin
    drv_nxt.dq = drv.dq;
    if (status_src || evt_on) drv_nxt.dq = byte_now;
    drv_nxt.dq_oe = oe_now;
    // dqs toggles on strobe events, held low while output is off
    drv_nxt.dqs = !out_on ? 1'b0 : (evt_on ? !drv.dqs : drv.dqs);
    drv_nxt.dqs_oe = oe_now && (mode != FSC_SDR);
  end

  // status index frozen, byte repeats per edge
  always_ff @(posedge clock) begin
    if (srst) begin
      drv <= '0;
      started_r <= 1'b0;
      div_r <= 1'b0;
    end else begin
      drv <= drv_nxt;
      started_r <= cmd_lat ? 1'b0 : (started_r || evt_on);
      div_r <= !div_r;
    end
  end

  // wishbone decode; unmapped words read zero, writes dropped
  wire wb_req = wb_cyc && wb_stb && !wb_ack;
  wire [3:0] widx = wb_adr[5:2];
  wire mapped = (wb_adr[7:6] == 2'b00) && (widx < 4'(`NUM_REGS));
  wire wb_wr = wb_req && wb_we && mapped;
  assign ecc_wr = wb_wr && (widx == `REG_ECC0 || widx == `REG_ECC1);
  wire [31:0] stat_word = {5'h00, crc_busy_r, lun_sel_r, busy_r, sb_plain, crc_fin_r};
  wire [31:0] rd_word = !mapped ? 32'h0000_0000 :
                        (widx == `REG_STAT) ? stat_word : rw_r[widx];
  logic [31:0] wmask;
  for (genvar b = 0; b < 4; b++) begin : g_sel
    assign wmask[8*b +: 8] = {8{wb_sel[b]}};
  end

  // writable words; status word slot is read-only
  for (genvar r = 0; r < `NUM_REGS; r++) begin : g_reg
    always_ff @(posedge clock) begin
      if (srst) begin
        rw_r[r] <= (r == `REG_CTRL) ? `CTRL_RST : 32'h0000_0000;
      end else if (wb_wr && widx == r && r != `REG_STAT) begin
        rw_r[r] <= (rw_r[r] & ~wmask) | (wb_dat_w & wmask);
      end
    end
  end

  // one-cycle registered answer
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack <= wb_req;
      // read data moves only on reads, so a write leaves the last answer
      wb_dat_r <= (wb_req && !wb_we) ? rd_word : wb_dat_r;
    end
  end
endmodule

// File: inc/fsc_map.svh
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// flash bus opcodes
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_UID 8'hED
`define CMD_PARAM 8'hEC
`define CMD_DATA 8'h00
`define ADDR_EXTP 8'h40
// address cycles per command
`define ROW_CYCLES 2'd3
`define ONE_CYCLE 2'd1
// row address layout
`define PLANE_BIT 7
`define LUN_BIT 20
`define BLK_LO 7
`define BLK_HI 23
`define BAD_BLK_HI 16
`define BAD_VALID 31
// status byte bit positions
`define SB_WP 7
`define SB_RDY 6
`define SB_ARRAY_READY_FLAG 5
`define SB_CSP 3
`define SB_PRIOR_OP_FAILED_FLAG 1
`define SB_FAIL 0
// extended page image
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h4F4E
`define EXT_CRC_LO 10'd0
`define EXT_CRC_HI 10'd1
`define EXT_FIRST 10'd2
`define EXT_SIG0_AT 10'd2
`define EXT_SIG1_AT 10'd3
`define EXT_SIG2_AT 10'd4
`define EXT_SIG3_AT 10'd5
`define EXT_SIG0 8'h45
`define EXT_SIG1 8'h50
`define EXT_SIG2 8'h50
`define EXT_SIG3 8'h53
`define SEC0_TYPE_AT 10'd16
`define SEC0_LEN_AT 10'd17
`define SEC0_TYPE 8'h02
`define SEC0_LEN 8'h01
`define SEC0_BASE 10'd32
`define ECC_END 10'd40
`define EXT_LAST 10'd47
`define UID_SPAN 10'd512
// register word indexes
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_UID0 4'h2
`define REG_ECC0 4'h6
`define REG_ECC1 4'h7
`define REG_BAD0 4'h8
`define NUM_REGS 12
`define NUM_BAD 4
`define CTRL_RST 32'h0000_0004
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_WP 2
// timing
`define CLK_MHZ 40
`define ERASE_US_DEF 2000
`define PINS_IDLE 13'h1300
`endif

// File: inc/fsc_pkg.sv
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_SDR = 2'b00, FSC_DDR1 = 2'b01, FSC_DDR2 = 2'b10
  } fsc_mode_t;
  typedef enum logic [1:0] {
    FSC_IDLE = 2'b00, FSC_ADDR = 2'b01, FSC_CONF = 2'b10, FSC_OUT = 2'b11
  } fsc_state_t;
  typedef enum logic [2:0] {
    FSC_NONE = 3'b000, FSC_STAT = 3'b001, FSC_ENH = 3'b010, FSC_UIDS = 3'b011,
    FSC_EXTP = 3'b100
  } fsc_src_t;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] dq;
  } fsc_pins_t;
  typedef struct packed {
    logic [7:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
  } fsc_drv_t;
  typedef struct packed {
    logic fail;
    logic prior_op_failed_flag;
    logic command_specific_flag;
  } fsc_plane_t;
endpackage

// File: verif/fsc_host.sv
`timescale 1ns/1ps
module fsc_host (
  // clock
  input wire logic clock,
  // device side
  input wire fsc_pkg::fsc_drv_t drv,
  output fsc_pkg::fsc_pins_t pins
);
  import fsc_pkg::*;
  // bus idle, chip deselected
  // target has no dqs input, idle dqs level stays with the host
  initial begin
    pins = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, dq: 8'h00};
  end
  // one latched cycle; levels held 4 clocks since the pins pass a 2-FF sync
  task automatic put(input logic c, input logic [7:0] b);
    pins.ce_n <= 1'b0;
    pins.cle <= c;
    pins.ale <= !c;
    pins.dq <= b;
    pins.we_n <= 1'b0;
    repeat (4) @(posedge clock);
    pins.we_n <= 1'b1;
    repeat (4) @(posedge clock);
    pins.cle <= 1'b0;
    pins.ale <= 1'b0;
    pins.dq <= ~b;
    repeat (2) @(posedge clock);
  endtask
  task automatic row(input logic [23:0] r);
    put(1'b0, r[7:0]);
    put(1'b0, r[15:8]);
    put(1'b0, r[23:16]);
  endtask
  // one sdr strobe, byte taken before the strobe rises
  task automatic get(output logic [7:0] q, output logic oe);
    pins.re_n <= 1'b0;
    repeat (6) @(posedge clock);
    q = drv.dq;
    oe = drv.dq_oe;
    pins.re_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  // ddr2 strobe, byte and dqs after the fall and after the rise
  task automatic get2(output logic [7:0] q0, output logic [7:0] q1, output logic [1:0] s,
                      output logic oe);
    pins.re_n <= 1'b0;
    repeat (6) @(posedge clock);
    q0 = drv.dq;
    s[1] = drv.dqs;
    oe = drv.dq_oe & drv.dqs_oe;
    pins.re_n <= 1'b1;
    repeat (6) @(posedge clock);
    q1 = drv.dq;
    s[0] = drv.dqs;
  endtask
  // ddr1 window with ale and cle both high; d is one when dqs moved
  task automatic win(output logic [7:0] q, output logic oe, output logic d);
    pins.cle <= 1'b1;
    pins.ale <= 1'b1;
    repeat (8) @(posedge clock);
    q = drv.dq;
    oe = drv.dq_oe & drv.dqs_oe;
    d = drv.dqs;
    repeat (2) @(posedge clock);
    d = d ^ drv.dqs;
    pins.cle <= 1'b0;
    pins.ale <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule

// File: verif/fsc_target_properties.sv
`timescale 1ns/1ps
module fsc_target_properties (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // flash bus
  input wire fsc_pkg::fsc_pins_t pins,
  input wire fsc_pkg::fsc_drv_t drv,
  // wishbone
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  import fsc_pkg::*;
  // status word answered this cycle; address still held by the master
  wire stat_rd = wb_ack && !wb_we && (wb_adr == 8'h04);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // bus handshake
  AST_ACK_NEXT: assert property ((wb_cyc && wb_stb && !wb_ack) |=> wb_ack)
    else $error("request not acknowledged next cycle");
  AST_ACK_ONE: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  AST_RDATA_HOLD: assert property ($changed(wb_dat_r) |-> (wb_ack && !wb_we))
    else $error("read data moved outside a read");
  AST_UNMAPPED: assert property ((wb_ack && !wb_we && wb_adr[7:6] != 2'h0) |->
    (wb_dat_r == 32'h0000_0000)) else $error("unmapped read not zero");
  // status byte layout
  AST_RSVD_ZERO: assert property (stat_rd |-> (wb_dat_r[20:18] == 3'h0))
    else $error("status bits 4 to 2 not zero");
  AST_BUSY_RDY: assert property (stat_rd |-> (wb_dat_r[22] == !wb_dat_r[24]))
    else $error("ready bit disagrees with busy");
  AST_ARRAY_READY_FLAG: assert property (stat_rd |-> (wb_dat_r[21] == wb_dat_r[22]))
    else $error("array ready disagrees with ready");
endmodule
bind fsc_target fsc_target_properties u_props (.clock(clock), .srst(srst), .pins(pins),
  .drv(drv), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
  .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

// File: verif/fsc_target_test.sv
`timescale 1ns/1ps
module fsc_target_test;
  import fsc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  fsc_pins_t pins;
  fsc_drv_t drv;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  int n_errors = 0;
  int check_count = 0;
  always #12.5 clock = ~clock;
  // short erase keeps the run brief
  fsc_target #(.ERASE_US(1), .LUN_ID(1'b0)) u_dut (.clock(clock), .srst(srst), .pins(pins),
    .drv(drv), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(4'hF), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
  fsc_host u_host (.clock(clock), .drv(drv), .pins(pins));
  task automatic complete_run;
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] idb(int i);
    return 8'h3C + 8'(i * 29);
  endfunction
  // classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat_r;
    if (wb_ack !== 1'b1) begin
      n_errors++;
      complete_run;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask
  // status command, then two strobes on the same byte
  task automatic st(input logic [7:0] op, input logic [23:0] r, input logic [7:0] e);
    logic [7:0] b;
    logic oe;
    u_host.put(1'b1, op);
    if (op == 8'h78) u_host.row(r);
    repeat (2) begin
      u_host.get(b, oe);
      chk({23'h0, oe, b}, {23'h0, 1'b1, e});
    end
  endtask
  task automatic erase(input logic [23:0] r);
    logic [31:0] q;
    int n;
    u_host.put(1'b1, 8'h60);
    u_host.row(r);
    u_host.put(1'b1, 8'hD0);
    n = 0;
    do begin
      wb(1'b0, 8'h04, 32'h0, q);
      n++;
    end while (q[24] !== 1'b0 && n < 40);
    // busy must clear within the poll limit
    if (q[24] !== 1'b0) begin
      n_errors++;
      complete_run;
    end
  endtask
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0000_0004);
    for (int k = 0; k < 4; k++)
      wb(1'b1, 8'h08 + 8'(4 * k), {idb(4*k+3), idb(4*k+2), idb(4*k+1), idb(4*k)}, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk(q, {idb(7), idb(6), idb(5), idb(4)});
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0000_0000);
  endtask
  // no enhanced status inside this stream, as the host must not issue one
  task automatic t_uid;
    logic [7:0] b;
    logic oe;
    logic [7:0] u [16];
    u_host.put(1'b1, 8'hED);
    u_host.put(1'b0, 8'h00);
    for (int i = 0; i < 64; i++) begin
      u_host.get(b, oe);
      chk({24'h0, b}, {24'h0, (i % 32 < 16) ? idb(i % 16) : ~idb(i % 16)});
      if (i % 32 < 16) u[i % 16] = b;
      else chk({24'h0, u[i % 16] ^ b}, 32'h0000_00FF);
    end
  endtask
  task automatic t_erase;
    logic [31:0] q;
    st(8'h70, 24'h0, 8'hE0);
    u_host.put(1'b1, 8'h60);
    u_host.row(24'h000080);
    u_host.put(1'b1, 8'hD0);
    st(8'h70, 24'h0, 8'h80);
    erase(24'h000080);
    st(8'h70, 24'h0, 8'hE0);
    wb(1'b1, 8'h20, 32'h8000_0002, q);
    erase(24'h000100);
    st(8'h70, 24'h0, 8'hE1);
    erase(24'h000100);
    st(8'h70, 24'h0, 8'hE3);
    erase(24'h000080);
    st(8'h70, 24'h0, 8'hE3);
  endtask
  task automatic t_enh;
    logic [7:0] b;
    logic oe;
    u_host.put(1'b1, 8'h78);
    u_host.row(24'h100000);
    u_host.get(b, oe);
    chk({31'h0, oe}, 32'h0000_0000);
    st(8'h78, 24'h000080, 8'hE0);
  endtask
  task automatic t_ext;
    logic [7:0] img [48];
    int hit;
    logic [15:0] c;
    logic [31:0] q;
    logic [7:0] b;
    logic oe;
    wb(1'b1, 8'h18, 32'h8877_6655, q);
    wb(1'b1, 8'h1C, 32'hCCBB_AA99, q);
    repeat (50) @(posedge clock);
    foreach (img[i]) img[i] = 8'h00;
    img[2] = 8'h45;
    img[3] = 8'h50;
    img[4] = 8'h50;
    img[5] = 8'h53;
    img[16] = 8'h02;
    img[17] = 8'h01;
    for (int i = 0; i < 8; i++) img[32+i] = 8'h55 + 8'(i * 17);
    c = 16'h4F4E;
    // msb first, poly 8005h, no final tweak
    for (int i = 2; i < 48; i++)
      for (int k = 7; k >= 0; k--) c = (c << 1) ^ ((c[15] ^ img[i][k]) ? 16'h8005 : 16'h0000);
    img[0] = c[7:0];
    img[1] = c[15:8];
    wb(1'b0, 8'h04, 32'h0, q);
    chk({16'h0, q[15:0]}, {16'h0, c});
    u_host.put(1'b1, 8'hEC);
    u_host.put(1'b0, 8'h40);
    hit = 0;
    for (int i = 0; i < 48; i++) begin
      if (i == 20) begin
        st(8'h78, 24'h000000, 8'hE3);
        u_host.put(1'b1, 8'h00);
      end
      u_host.get(b, oe);
      chk({24'h0, b}, {24'h0, img[i]});
      if (i >= 2 && i < 6 && b === img[i]) hit++;
    end
    chk({31'h0, hit >= 2}, 32'h0000_0001);
  endtask
  // both ddr modes on the plain status command, then back to sdr
  task automatic t_ddr;
    logic [31:0] q;
    logic [7:0] b0, b1;
    logic [1:0] s;
    logic oe, d;
    wb(1'b1, 8'h00, 32'h0000_0006, q);
    u_host.put(1'b1, 8'h70);
    u_host.get2(b0, b1, s, oe);
    chk({21'h0, oe, s, b0}, {21'h0, 1'b1, 2'b10, 8'hE3});
    chk({24'h0, b1}, {24'h0, 8'hE3});
    wb(1'b1, 8'h00, 32'h0000_0005, q);
    u_host.put(1'b1, 8'h70);
    u_host.win(b0, oe, d);
    chk({22'h0, d, oe, b0}, {22'h0, 1'b1, 1'b1, 8'hE3});
    wb(1'b1, 8'h00, 32'h0000_0004, q);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_uid;
    t_erase;
    t_enh;
    t_ext;
    t_ddr;
    complete_run;
  end
endmodule
